// ===== dv/dtc_pin_model.sv
// Far-side pin model: count inputs and interrupt pins of the timer block
module dtc_pin_model (
	input wire logic ref_clk,
	output logic count_input0_pin,
	output logic count_input1_pin,
	output logic ext_irq0_pin,
	output logic ext_irq1_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// Idle levels: pins rest high, count input 1 is left unused
	initial begin
		count_input0_pin = 1'b1;
		count_input1_pin = 1'b1;
		ext_irq0_pin = 1'b1;
		ext_irq1_pin = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// ==========================================
	// levels held two machine cycles
	task automatic pulse0(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			count_input0_pin <= 1'b0;
			hold(24);
			count_input0_pin <= 1'b1;
			hold(24);
		end
	endtask

	task automatic set_irq(input int i, input logic v);
		@(posedge ref_clk);
		if (i == 0) begin
			ext_irq0_pin <= v;
		end else begin
			ext_irq1_pin <= v;
		end
		hold(24);
	endtask
endmodule

// ===== dv/tb_dtc_top.sv
// Self-checking bench for the dual timer/counter block
`include "dtc_params.svh"

module tb_dtc_top
	import dtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk = 1'b0, resetn = 1'b0, soft_reset = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
	logic [1:0] tva = 2'h0, eva = 2'h0;
	logic [7:0] sfr_rdata;
	logic t0_of, t1_of, x0_f, x1_f, baud, c0, c1, i0, i1;
	logic [4:0] fl;
	int miscompares = 0, samples_checked = 0;

	assign fl = {baud, x1_f, x0_f, t1_of, t0_of};

	// ==========================================
	// Clock, design and pin model
	always #12.5 ref_clk = ~ref_clk;

	dtc_top uut (.ref_clk(ref_clk), .resetn(resetn), .soft_reset(soft_reset), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.timer_vector_ack(tva), .ext_irq_vector_ack(eva), .count_input0_pin(c0),
		.count_input1_pin(c1), .ext_irq0_pin(i0), .ext_irq1_pin(i1), .t0_overflow_flag(t0_of),
		.t1_overflow_flag(t1_of), .ext_irq0_flag(x0_f), .ext_irq1_flag(x1_f), .t1_baud_pulse(baud));

	dtc_pin_model pm (.ref_clk(ref_clk), .count_input0_pin(c0), .count_input1_pin(c1),
		.ext_irq0_pin(i0), .ext_irq1_pin(i1));

	// ==========================================
	// Reporting and compares
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t: read %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk1(input logic g, input logic e, input string m);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic fin(input string s);
		$display("Test %s finished", s);
	endtask

	// ==========================================
	// SFR bus cycles: one-cycle strobes, read data one cycle later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1;
		chk8(sfr_rdata, e);
	endtask

	task automatic ack(input logic [1:0] t, input logic [1:0] x);
		@(posedge ref_clk);
		tva <= t;
		eva <= x;
		@(posedge ref_clk);
		tva <= 2'h0;
		eva <= 2'h0;
		#1;
	endtask

	// Bounded wait for one flag to reach a level
	task automatic wf(input int i, input logic v, input int n, input string m);
		bit hit;
		hit = 1'b0;
		for (int k = 0; k < n && !hit; k++) begin
			@(posedge ref_clk);
			#1;
			hit = (fl[i] === v);
		end
		chk1(hit, 1'b1, m);
		if (!hit) begin
			wrap_up();
		end
	endtask

	task automatic zeros();
		for (int a = `DTC_ADDR_TIMER_CONTROL; a <= `DTC_ADDR_TH1; a++) begin
			rd(8'(a), 8'h00);
		end
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		zeros();
		for (int a = `DTC_ADDR_TIMER_MODE_REGISTER; a <= `DTC_ADDR_TH1; a++) begin
			wr(8'(a), 8'(a) ^ 8'hC3);
			rd(8'(a), 8'(a) ^ 8'hC3);
		end
		wr(8'h90, 8'h5A);
		rd(8'h90, 8'h00);
		fin("registers");
		// Both timers in 16-bit mode roll over together
		wr(`DTC_ADDR_TIMER_MODE_REGISTER, 8'h11);
		for (int a = `DTC_ADDR_TL0; a <= `DTC_ADDR_TH1; a++) begin
			wr(8'(a), 8'hFF);
		end
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h50);
		wf(0, 1'b1, 40, "timer 0 overflow flag");
		wf(1, 1'b1, 2, "timer 1 overflow flag");
		rd(`DTC_ADDR_TIMER_CONTROL, 8'hF0);
		rd(`DTC_ADDR_TH0, 8'h00);
		rd(`DTC_ADDR_TH1, 8'h00);
		ack(2'h3, 2'h0);
		chk1(t0_of | t1_of, 1'b0, "overflow flags after ack");
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h00);
		wr(`DTC_ADDR_TH0, 8'h12);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h10);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h00);
		rd(`DTC_ADDR_TH0, 8'h12);
		fin("mode 1");
		// Auto-reload
		wr(`DTC_ADDR_TIMER_MODE_REGISTER, 8'h02);
		wr(`DTC_ADDR_TH0, 8'hF0);
		wr(`DTC_ADDR_TL0, 8'hFE);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h10);
		wf(0, 1'b1, 60, "reload overflow");
		rd(`DTC_ADDR_TL0, 8'hF0);
		rd(`DTC_ADDR_TH0, 8'hF0);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h00);
		fin("mode 2");
		// 13-bit: two high-byte steps take 64 machine cycles
		wr(`DTC_ADDR_TIMER_MODE_REGISTER, 8'h00);
		wr(`DTC_ADDR_TH0, 8'hFE);
		wr(`DTC_ADDR_TL0, 8'h00);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h10);
		repeat (740) @(posedge ref_clk);
		chk1(t0_of, 1'b0, "prescaled overflow too early");
		wf(0, 1'b1, 60, "prescaled overflow");
		rd(`DTC_ADDR_TH0, 8'h00);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h00);
		fin("mode 0");
		// Gate holds the count while the pin is low
		wr(`DTC_ADDR_TIMER_MODE_REGISTER, 8'h09);
		wr(`DTC_ADDR_TL0, 8'hFF);
		wr(`DTC_ADDR_TH0, 8'hFF);
		pm.set_irq(0, 1'b0);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h10);
		repeat (60) @(posedge ref_clk);
		chk1(t0_of, 1'b0, "gated timer counted");
		pm.set_irq(0, 1'b1);
		wf(0, 1'b1, 60, "gate open overflow");
		fin("gate");
		// Counter function on the count pin
		wr(`DTC_ADDR_TIMER_MODE_REGISTER, 8'h05);
		wr(`DTC_ADDR_TL0, 8'h00);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h10);
		pm.pulse0(3);
		rd(`DTC_ADDR_TL0, 8'h03);
		fin("counter");
		// Interrupt pins, edge then level triggering
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h05);
		pm.set_irq(0, 1'b0);
		wf(2, 1'b1, 40, "edge flag 0");
		ack(2'h0, 2'h1);
		chk1(x0_f, 1'b0, "edge flag 0 after ack");
		pm.set_irq(1, 1'b0);
		wf(3, 1'b1, 40, "edge flag 1");
		ack(2'h0, 2'h2);
		chk1(x1_f, 1'b0, "edge flag 1 after ack");
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h00);
		wf(3, 1'b1, 40, "level flag 1");
		pm.set_irq(1, 1'b1);
		wf(3, 1'b0, 40, "level flag 1 release");
		ack(2'h0, 2'h1);
		chk1(x0_f, 1'b1, "level flag 0 ack ignored");
		pm.set_irq(0, 1'b1);
		wf(2, 1'b0, 40, "level flag 0 release");
		fin("external interrupts");
		// Split mode
		wr(`DTC_ADDR_TIMER_MODE_REGISTER, 8'h23);
		wr(`DTC_ADDR_TH1, 8'hFF);
		wr(`DTC_ADDR_TL1, 8'hFF);
		wr(`DTC_ADDR_TH0, 8'hFF);
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h50);
		wf(4, 1'b1, 40, "baud pulse");
		wf(1, 1'b1, 40, "high byte sets timer 1 flag");
		wr(`DTC_ADDR_TIMER_CONTROL, 8'h10);
		wf(4, 1'b1, 40, "baud pulse with run bit clear");
		wr(`DTC_ADDR_TIMER_MODE_REGISTER, 8'h33);
		wr(`DTC_ADDR_TL1, 8'h05);
		repeat (40) @(posedge ref_clk);
		rd(`DTC_ADDR_TL1, 8'h05);
		fin("mode 3");
		// Synchronous clear while running
		@(posedge ref_clk);
		soft_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		zeros();
		chk1(t1_of, 1'b0, "flag after clear");
		fin("clear");
		wrap_up();
	end
endmodule

// ===== src/dtc_params.svh
// Constants for the dual timer/counter: addresses, bit positions, reset values, timing
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ==========================================
// Register addresses on the SFR bus
`define DTC_ADDR_TIMER_CONTROL 8'h88
`define DTC_ADDR_TIMER_MODE_REGISTER 8'h89
`define DTC_ADDR_TL0 8'h8A
`define DTC_ADDR_TL1 8'h8B
`define DTC_ADDR_TH0 8'h8C
`define DTC_ADDR_TH1 8'h8D

// ==========================================
// Control register bit positions
`define DTC_TIMER_CONTROL_TF1 7
`define DTC_TIMER_CONTROL_TR1 6
`define DTC_TIMER_CONTROL_TF0 5
`define DTC_TIMER_CONTROL_TR0 4
`define DTC_TIMER_CONTROL_IE1 3
`define DTC_TIMER_CONTROL_IT1 2
`define DTC_TIMER_CONTROL_IE0 1
`define DTC_TIMER_CONTROL_IT0 0

// ==========================================
// Mode register field positions, timer 1 sits one nibble up
`define DTC_TIMER_MODE_REGISTER_GATE 3
`define DTC_TIMER_MODE_REGISTER_CT 2
`define DTC_TIMER_MODE_REGISTER_M1 1
`define DTC_TIMER_MODE_REGISTER_M0 0
`define DTC_TIMER_MODE_REGISTER_T1_BASE 4

// ==========================================
// Reset values and timing
`define DTC_RST_BYTE 8'h00
`define DTC_UNMAPPED_READ 8'h00
`define DTC_MC_CLKS 4'd12
`define DTC_PIN_IDLE 4'hF
`define DTC_PIN_CNT0 0
`define DTC_PIN_CNT1 1
`define DTC_PIN_IRQ0 2
`define DTC_PIN_IRQ1 3

`endif

// ===== src/dtc_pkg.sv
// Types shared by the dual timer/counter modules
package dtc_pkg;

	// ==========================================
	// Operating modes, encoded as the two mode bits
	typedef enum logic [1:0] {
		DTC_MODE_13BIT = 2'b00,
		DTC_MODE_16BIT = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_t;

	// ==========================================
	// Sampler state: synchronisers, machine-cycle counter, samples
	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] samp;
		logic [3:0] fall;
		logic [3:0] mc;
		logic tick;
	} dtc_tick_state_t;

	// ==========================================
	// Timer block state
	typedef struct packed {
		logic [1:0][7:0] tl;
		logic [1:0][7:0] th;
		logic [7:0] timer_mode_register;
		logic [1:0] tf;
		logic [1:0] tr;
		logic [1:0] ie;
		logic [1:0] it;
		logic [7:0] rdata;
		logic baud;
	} dtc_state_t;

endpackage

// ===== src/dtc_tick.sv
// Machine-cycle generator and per-cycle pin sampler
`include "dtc_params.svh"

module dtc_tick
	import dtc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] pins,
	dtc_tick_if.src tk
);

	dtc_tick_state_t q;
	dtc_tick_state_t d;

	// ==========================================
	// Next state: two-stage sync, then one sample per machine cycle
	always_comb begin
		d = q;
		d.sync1 = pins;
		d.sync2 = q.sync1;
		d.tick = 1'b0;
		d.fall = 4'h0;
		if (q.mc == `DTC_MC_CLKS - 4'd1) begin
			d.mc = 4'h0;
			d.tick = 1'b1;
			d.samp = q.sync2;
			d.fall = q.samp & ~q.sync2;
		end else begin
			d.mc = q.mc + 4'd1;
		end
	end

	// State register, pin history reset to the idle-high level so no false edge or level follows reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{sync1: `DTC_PIN_IDLE, sync2: `DTC_PIN_IDLE, samp: `DTC_PIN_IDLE, fall: 4'h0, mc: 4'h0, tick: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Outputs to the core
	assign tk.tick = q.tick;
	assign tk.level = q.samp;
	assign tk.fall = q.fall;

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_tick_period;
		q.tick |=> (!q.tick) [*8] ##1 !q.tick ##1 !q.tick ##1 !q.tick ##1 q.tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("machine cycle is not 12 clocks");

	property p_fall_on_tick;
		(q.fall != 4'h0) |-> q.tick;
	endproperty
	a_fall_on_tick: assert property (p_fall_on_tick) else $error("pin fall seen off a machine cycle");

endmodule

// ===== src/dtc_tick_if.sv
// Link from the pin sampler to the timer core
interface dtc_tick_if;
	logic tick;
	logic [3:0] level;
	logic [3:0] fall;

	modport src (
		output tick,
		output level,
		output fall
	);
	modport snk (
		input tick,
		input level,
		input fall
	);
endinterface

// ===== src/dtc_top.sv
// Dual timer/counter with control, mode and count registers on the SFR bus
//
// Contract
// - Timer 1 overflow flag, control bit 7, set on overflow, cleared on vectoring.
// - Control bit 6 switches timer 1 on when 1, off when 0.
// - Timer 0 overflow flag, control bit 5, set on overflow, cleared on vectoring.
// - Control bit 4 starts timer 0 when 1, stops it when 0.
// - Interrupt 1 flag, bit 3: edge flag cleared on vectoring, level flag follows pin.
// - Bit 2 picks falling edge (1) or low level (0) for interrupt 1.
// - Interrupt 0 flag, bit 1: edge flag cleared on vectoring, level flag follows pin.
// - Bit 0 picks falling edge (1) or low level (0) for interrupt 0.
// - Mode 0 counts 13 bits: high byte plus low five bits as prescaler.
// - Rollover from all ones to zero sets the timer's overflow flag.
// - Count only when run bit set and gate clear or interrupt pin high.
// - Setting the run bit leaves the count registers untouched.
// - Mode 1 cascades both bytes into a 16-bit counter, no prescaler.
// - Mode 2 low byte reloads from high byte on overflow, flag set.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Timer 0 mode 3: low byte own counter, high byte timed by timer 1 controls.
// - Timer 1 then runs outside mode 3, its overflow still feeds the baud pulse.
// - Mode register nibbles hold gate, counter select and two mode bits.
// - Counter select 1 counts the count pin, 0 counts machine cycles.
// - Timer function advances once per machine cycle of twelve clocks.
// - Counter function counts a high sample followed by a low sample.
`include "dtc_params.svh"

module dtc_top
	import dtc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic soft_reset,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [1:0] timer_vector_ack,
	input wire logic [1:0] ext_irq_vector_ack,
	input wire logic count_input0_pin,
	input wire logic count_input1_pin,
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	output logic t0_overflow_flag,
	output logic t1_overflow_flag,
	output logic ext_irq0_flag,
	output logic ext_irq1_flag,
	output logic t1_baud_pulse
);

	dtc_state_t q;
	dtc_state_t d;
	dtc_tick_if tk ();

	// ==========================================
	// Pin sampler
	dtc_tick u_tick (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pins({ext_irq1_pin, ext_irq0_pin, count_input1_pin, count_input0_pin}),
		.tk(tk.src)
	);

	// ==========================================
	// One counting step of a timer in the given mode: {overflow, high, low}
	function automatic logic [16:0] dtc_step(input dtc_mode_t mode, input logic [7:0] th, input logic [7:0] tl);
		logic [5:0] pre;
		logic [16:0] wide;
		logic [16:0] res;
		pre = {1'b0, tl[4:0]} + 6'h01;
		wide = {1'b0, th, tl} + 17'h00001;
		res = {1'b0, th, tl};
		case (mode)
			DTC_MODE_13BIT: begin
				res = {pre[5] & (th == 8'hFF), pre[5] ? th + 8'h01 : th, tl[7:5], pre[4:0]};
			end
			DTC_MODE_16BIT: begin
				res = wide;
			end
			DTC_MODE_RELOAD: begin
				res = (tl == 8'hFF) ? {1'b1, th, th} : {1'b0, th, tl + 8'h01};
			end
			DTC_MODE_SPLIT: begin
				res = {tl == 8'hFF, th, tl + 8'h01};
			end
			default: begin
				res = {1'b0, th, tl};
			end
		endcase
		return res;
	endfunction

	// ==========================================
	// Per-timer mode decode, enables and step results
	dtc_mode_t mode [2];
	logic [1:0] run_ok;
	logic [1:0] evt;
	logic [16:0] step [2];

	for (genvar i = 0; i < 2; i++) begin : g_timer
		assign mode[i] = dtc_mode_t'(q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_T1_BASE * i + `DTC_TIMER_MODE_REGISTER_M1 -: 2]);
		assign run_ok[i] = q.tr[i] & (~q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_T1_BASE * i + `DTC_TIMER_MODE_REGISTER_GATE] | tk.level[`DTC_PIN_IRQ0 + i]);
		assign evt[i] = q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_T1_BASE * i + `DTC_TIMER_MODE_REGISTER_CT] ? tk.fall[`DTC_PIN_CNT0 + i] : tk.tick;
		assign step[i] = dtc_step(mode[i], q.th[i], q.tl[i]);
	end

	// ==========================================
	// Increment requests and overflow sources
	logic t0_split;
	logic inc0;
	logic inc1;
	logic inc_split_hi;
	logic [1:0] tf_set;
	logic t1_ovf;
	logic timer_control_wr;
	logic [7:0] timer_control_val;

	assign t0_split = (mode[0] == DTC_MODE_SPLIT);
	assign inc0 = evt[0] & run_ok[0];
	// mode switch starts timer 1, its run bit belongs to the split high byte
	assign inc1 = evt[1] & (t0_split | run_ok[1]) & (mode[1] != DTC_MODE_SPLIT);
	assign inc_split_hi = t0_split & tk.tick & q.tr[1];
	assign t1_ovf = inc1 & step[1][16];
	assign tf_set[0] = inc0 & step[0][16];
	assign tf_set[1] = t0_split ? (inc_split_hi & (q.th[0] == 8'hFF)) : t1_ovf;
	assign timer_control_wr = sfr_wr & (sfr_addr == `DTC_ADDR_TIMER_CONTROL);
	assign timer_control_val = {q.tf[1], q.tr[1], q.tf[0], q.tr[0], q.ie[1], q.it[1], q.ie[0], q.it[0]};

	// ==========================================
	// Next state
	always_comb begin
		d = q;
		d.baud = 1'b0;
		// Timer 0 counting
		if (inc0) begin
			d.tl[0] = step[0][7:0];
			if (!t0_split) begin
				d.th[0] = step[0][15:8];
			end
		end
		// Timer 0 high byte as its own timer
		if (inc_split_hi) begin
			d.th[0] = q.th[0] + 8'h01;
		end
		// Timer 1 counting
		if (inc1) begin
			d.tl[1] = step[1][7:0];
			d.th[1] = step[1][15:8];
		end
		d.baud = t1_ovf;
		// Software writes to data and mode registers win over counting
		if (sfr_wr) begin
			case (sfr_addr)
				`DTC_ADDR_TL0: d.tl[0] = sfr_wdata;
				`DTC_ADDR_TL1: d.tl[1] = sfr_wdata;
				`DTC_ADDR_TH0: d.th[0] = sfr_wdata;
				`DTC_ADDR_TH1: d.th[1] = sfr_wdata;
				`DTC_ADDR_TIMER_MODE_REGISTER: d.timer_mode_register = sfr_wdata;
				default: d.timer_mode_register = q.timer_mode_register;
			endcase
		end
		if (timer_control_wr) begin
			d.tr[1] = sfr_wdata[`DTC_TIMER_CONTROL_TR1];
			d.tr[0] = sfr_wdata[`DTC_TIMER_CONTROL_TR0];
			d.it[1] = sfr_wdata[`DTC_TIMER_CONTROL_IT1];
			d.it[0] = sfr_wdata[`DTC_TIMER_CONTROL_IT0];
		end
		d.tf[1] = (timer_control_wr ? sfr_wdata[`DTC_TIMER_CONTROL_TF1] : (q.tf[1] & ~timer_vector_ack[1])) | tf_set[1];
		d.tf[0] = (timer_control_wr ? sfr_wdata[`DTC_TIMER_CONTROL_TF0] : (q.tf[0] & ~timer_vector_ack[0])) | tf_set[0];
		if (q.it[1]) begin
			d.ie[1] = (timer_control_wr ? sfr_wdata[`DTC_TIMER_CONTROL_IE1] : (q.ie[1] & ~ext_irq_vector_ack[1]))
				| tk.fall[`DTC_PIN_IRQ1];
		end else begin
			d.ie[1] = ~tk.level[`DTC_PIN_IRQ1];
		end
		if (q.it[0]) begin
			d.ie[0] = (timer_control_wr ? sfr_wdata[`DTC_TIMER_CONTROL_IE0] : (q.ie[0] & ~ext_irq_vector_ack[0]))
				| tk.fall[`DTC_PIN_IRQ0];
		end else begin
			d.ie[0] = ~tk.level[`DTC_PIN_IRQ0];
		end
		// Read data register, one cycle after the strobe
		if (sfr_rd) begin
			case (sfr_addr)
				`DTC_ADDR_TIMER_CONTROL: d.rdata = timer_control_val;
				`DTC_ADDR_TIMER_MODE_REGISTER: d.rdata = q.timer_mode_register;
				`DTC_ADDR_TL0: d.rdata = q.tl[0];
				`DTC_ADDR_TL1: d.rdata = q.tl[1];
				`DTC_ADDR_TH0: d.rdata = q.th[0];
				`DTC_ADDR_TH1: d.rdata = q.th[1];
				default: d.rdata = `DTC_UNMAPPED_READ;
			endcase
		end
		if (soft_reset) begin
			d.tl = {2{`DTC_RST_BYTE}};
			d.th = {2{`DTC_RST_BYTE}};
			d.timer_mode_register = `DTC_RST_BYTE;
			d.tf = 2'b00;
			d.tr = 2'b00;
			d.ie = 2'b00;
			d.it = 2'b00;
			d.baud = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign sfr_rdata = q.rdata;
	assign t0_overflow_flag = q.tf[0];
	assign t1_overflow_flag = q.tf[1];
	assign ext_irq0_flag = q.ie[0];
	assign ext_irq1_flag = q.ie[1];
	assign t1_baud_pulse = q.baud;

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic quiet;
	assign quiet = !sfr_wr && !soft_reset;

	property p_tf1_clear;
		quiet && q.tf[1] && timer_vector_ack[1] && !tf_set[1] |=> !q.tf[1];
	endproperty
	a_tf1_clear: assert property (p_tf1_clear) else $error("timer 1 flag not cleared on vectoring");

	property p_tf0_set;
		!soft_reset && inc0 && mode[0] == DTC_MODE_16BIT && q.tl[0] == 8'hFF && q.th[0] == 8'hFF |=> q.tf[0];
	endproperty
	a_tf0_set: assert property (p_tf0_set) else $error("timer 0 flag not set on 16-bit rollover");

	property p_stopped_hold;
		quiet && !q.tr[0] |=> $stable(q.tl[0]);
	endproperty
	a_stopped_hold: assert property (p_stopped_hold) else $error("timer 0 low byte moved while stopped");

	property p_edge_irq1;
		!soft_reset && q.it[1] && tk.fall[`DTC_PIN_IRQ1] |=> q.ie[1];
	endproperty
	a_edge_irq1: assert property (p_edge_irq1) else $error("edge on irq 1 pin lost");

	property p_level_irq0;
		!soft_reset && !q.it[0] ##1 !q.it[0] |-> q.ie[0] == !$past(tk.level[`DTC_PIN_IRQ0]);
	endproperty
	a_level_irq0: assert property (p_level_irq0) else $error("level irq 0 flag does not follow pin");

	property p_prescale;
		quiet && inc0 && mode[0] == DTC_MODE_13BIT && q.tl[0][4:0] != 5'h1F |=> $stable(q.th[0]);
	endproperty
	a_prescale: assert property (p_prescale) else $error("mode 0 high byte moved before prescaler wrap");

	property p_reload;
		quiet && inc0 && mode[0] == DTC_MODE_RELOAD && q.tl[0] == 8'hFF |=> q.tl[0] == $past(q.th[0])
			&& $stable(q.th[0]) && q.tf[0];
	endproperty
	a_reload: assert property (p_reload) else $error("mode 2 reload wrong");

	property p_t1_mode3_hold;
		quiet && mode[1] == DTC_MODE_SPLIT |=> $stable(q.tl[1]) && $stable(q.th[1]);
	endproperty
	a_t1_mode3_hold: assert property (p_t1_mode3_hold) else $error("timer 1 counted in mode 3");

	property p_split_hi;
		quiet && t0_split && tk.tick && q.tr[1] |=> q.th[0] == $past(q.th[0]) + 8'h01;
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split high byte did not advance");

	property p_soft_clear;
		soft_reset |=> q.tr == 2'b00 && q.timer_mode_register == 8'h00 && q.tl[0] == 8'h00 && q.th[1] == 8'h00;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("synchronous clear incomplete");

	c_t0_overflow: cover property (tf_set[0]);
	c_split_overflow: cover property (t0_split && tf_set[1]);
	c_edge_irq0: cover property (q.it[0] && tk.fall[`DTC_PIN_IRQ0]);
	c_reload: cover property (inc0 && mode[0] == DTC_MODE_RELOAD && q.tl[0] == 8'hFF);

endmodule
